/* File: rtl/acs_pkg.sv */
// constants shared by the converter clock, input and scan control block
package acs_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [7:0] ADR_CLKTIME = 8'h00;
  localparam logic [7:0] ADR_INSEL   = 8'h04;
  localparam logic [7:0] ADR_BGCFG   = 8'h08;
  localparam logic [7:0] ADR_SCANLO  = 8'h0c;
  localparam logic [7:0] ADR_SCANHI  = 8'h10;
  localparam logic [7:0] ADR_CTRL    = 8'h14;
  localparam logic [7:0] ADR_STAT    = 8'h18;
  // reset values, all cleared at power-on
  localparam logic [15:0] RST_REG16  = 16'h0000;
  // implemented bits per register
  localparam logic [15:0] MSK_CLKTIME = 16'hffff;
  localparam logic [15:0] MSK_INSEL   = 16'h9f9f;
  localparam logic [15:0] MSK_BGCFG   = 16'h0007;
  localparam logic [15:0] MSK_SCANHI  = 16'h0fff;
  localparam logic [15:0] MSK_SCANHI_SMALL = 16'h0f00;
  localparam logic [15:0] MSK_CTRL    = 16'h84e5;
  // clock and timing register fields
  localparam int CLK_SRC_BIT = 15;
  localparam int AUTO_SAMPLE_COUNT_LSB    = 8;
  localparam int DIV_LSB     = 0;
  // input select register fields
  localparam int NEGB_BIT    = 15;
  localparam int POSB_LSB    = 8;
  localparam int NEGA_BIT    = 7;
  localparam int POSA_LSB    = 0;
  // band gap enable fields
  localparam int BG_FULL_BIT  = 0;
  localparam int BG_HALF_BIT  = 1;
  localparam int BG_SIXTH_BIT = 2;
  // control register fields
  localparam int CTRL_ON_BIT   = 15;
  localparam int CTRL_SCAN_BIT = 10;
  localparam int CTRL_TRIG_LSB = 5;
  localparam int CTRL_ASAM_BIT = 2;
  localparam int CTRL_SAMP_BIT = 1;
  localparam int CTRL_ALT_BIT  = 0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  // positive select codes
  localparam logic [4:0] CODE_LAST_AN       = 5'h17;
  localparam logic [4:0] CODE_LAST_AN_SMALL = 5'h0f;
  localparam logic [4:0] CODE_BG_HALF       = 5'h18;
  localparam logic [4:0] CODE_BG_SIXTH      = 5'h1b;
  localparam logic [4:0] CODE_FLOAT         = 5'h1f;
  // scan mask width: 24 pins plus four internal sources
  localparam int SCAN_W = 28;
  // timing: clk_i is the oscillator, the instruction cycle is two of it
  localparam int TOSC_NS = 40;
  localparam int TCY_NS  = 80;
  localparam int HALF_TCY_CLKS = TCY_NS / (2 * TOSC_NS);
  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } acs_state_e;
endpackage : acs_pkg

/* File: rtl/acs_core_if.sv */
// links between the control top, the clock divider and the scan stepper
`timescale 1ns/10ps
interface acs_core_if;
  logic        ce;           // global clock enable
  logic        clk_src_rc;   // 1 = rc oscillator drives the clock
  logic [7:0]  div;          // divider field
  logic        restart;      // divider rewritten
  logic        rc_rise;      // synced rc rising edge
  logic        tad_tick;     // one per conversion clock period
  logic        conv_clk;     // conversion clock level
  logic [27:0] scan_mask;    // selected scan inputs
  logic        scan_restart; // go back to lowest input
  logic        scan_advance; // step to next input
  logic [4:0]  scan_idx;     // current scan input code
  logic        scan_any;     // any input selected
  modport ctl (output ce, clk_src_rc, div, restart, rc_rise,
               scan_mask, scan_restart, scan_advance,
               input tad_tick, conv_clk, scan_idx, scan_any);
  modport clkdiv (input ce, clk_src_rc, div, restart, rc_rise,
                  output tad_tick, conv_clk);
  modport scan (input ce, scan_mask, scan_restart, scan_advance,
                output scan_idx, scan_any);
endinterface : acs_core_if

/* File: rtl/acs_clkdiv.sv */
// conversion clock generator: divided system clock or rc oscillator
`timescale 1ns/10ps
module acs_clkdiv (
  input  wire logic clk_i,
  input  wire logic rst_i,
  acs_core_if.clkdiv cif
);
  logic [8:0] cnt_reg,  cnt_next;  // half period down counter
  logic       clk_reg,  clk_next;  // conversion clock level
  logic       tick_reg, tick_next; // period tick
  logic [8:0] reload;              // half period minus one

  // half period is (div+1) instruction half cycles
  assign reload = 9'((({1'b0, cif.div} + 9'h001)
    * acs_pkg::HALF_TCY_CLKS) - 1);

  // counter reloads and toggles the clock on expiry
  always_comb begin
    cnt_next  = cnt_reg;
    clk_next  = clk_reg;
    tick_next = 1'b0;
    if (cif.restart) begin
      cnt_next = reload;  // see [RULE20]
      clk_next = 1'b0;
    end else if (cif.clk_src_rc) begin
      // rc source: each rc rising edge is one period, see [RULE1]
      clk_next  = cif.rc_rise;
      tick_next = cif.rc_rise;
    end else if (cnt_reg == 9'h000) begin
      cnt_next  = reload;     // see [RULE4]
      clk_next  = ~clk_reg;   // see [RULE20]
      tick_next = ~clk_reg;   // tick on rising half
    end else begin
      cnt_next = cnt_reg - 9'h001;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= 9'h000;
      clk_reg  <= 1'b0;
      tick_reg <= 1'b0;
    end else if (cif.ce) begin
      cnt_reg  <= cnt_next;
      clk_reg  <= clk_next;
      tick_reg <= tick_next;
    end
  end

  assign cif.tad_tick = tick_reg & cif.ce;
  assign cif.conv_clk = clk_reg;
endmodule : acs_clkdiv

/* File: rtl/acs_scan.sv */
// scan stepper: walks the set mask bits upward with wrap
`timescale 1ns/10ps
module acs_scan (
  input  wire logic clk_i,
  input  wire logic rst_i,
  acs_core_if.scan  sif
);
  localparam int W = acs_pkg::SCAN_W;
  logic [4:0] idx_reg, idx_next; // current input code
  logic [4:0] lowest;            // lowest set bit
  logic [4:0] upper;             // next set bit above current
  logic       found;             // a higher bit exists

  // search for lowest and next higher set bit
  always_comb begin
    lowest = 5'h00;
    upper  = 5'h00;
    found  = 1'b0;
    for (int k = W - 1; k >= 0; k--) begin
      if (sif.scan_mask[k]) begin
        lowest = 5'(k);
        if (5'(k) > idx_reg) begin
          upper = 5'(k);
          found = 1'b1;
        end
      end
    end
  end

  // ascending step, wrap to lowest selected
  always_comb begin
    idx_next = idx_reg;
    if (sif.scan_restart) begin
      idx_next = lowest;                      // see [RULE19]
    end else if (sif.scan_advance) begin
      idx_next = found ? upper : lowest;      // see [RULE19]
    end
  end

  // position register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_reg <= 5'h00;
    end else if (sif.ce) begin
      idx_reg <= idx_next;
    end
  end

  assign sif.scan_idx = idx_reg;
  assign sif.scan_any = |sif.scan_mask;
endmodule : acs_scan

/* File: rtl/acs_top.sv */
// converter clock, input select and scan control with wishbone registers
// Behaviour
// [RULE1] rc oscillator clock when source bit set
// [RULE2] software keeps reserved timing bits zero
// [RULE3] sample time is count times clock periods
// [RULE4] clock period is divider plus one cycles
// [RULE5] second setting negative input ain1 or reference
// [RULE6] second setting positive select code decode
// [RULE7] software avoids unimplemented positive select codes
// [RULE8] first setting negative input ain1 or reference
// [RULE9] first setting positive select same decode
// [RULE10] small package lacks inputs sixteen to 23
// [RULE11] three band gap enable bits drive references
// [RULE12] band gap upper bits read zero
// [RULE13] low scan mask selects inputs zero-15
// [RULE14] high mask low byte selects 16-23
// [RULE15] high mask bits 8-11 select internal sources
// [RULE16] auto trigger ends sampling after sample time
// [RULE17] alternate: first setting, then alternate settings
// [RULE18] scan replaces first setting positive select
// [RULE19] scan ascends through mask bits, wrapping
// [RULE20] divider counter reloads, toggles, restarts on rewrite
`timescale 1ns/10ps
module acs_top #(
  parameter bit SMALL_PKG = 1'b0,  // 1 = smaller package variant
  parameter int ADR_W     = 8      // wishbone address width
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             rc_clk_i,
  input  wire logic             conv_done_i,
  output logic                  conv_clk_o,
  output logic                  sample_o,
  output logic                  convert_start_o,
  output logic      [4:0]       pos_sel_o,
  output logic                  neg_ain1_o,
  output logic                  bg_sixth_en_o,
  output logic                  bg_half_en_o,
  output logic                  bg_full_en_o
);
  acs_core_if cif ();  // link to divider and scan stepper

  // software registers
  logic [15:0] clkt_reg, clkt_next;   // clock and sample time
  logic [15:0] insel_reg, insel_next; // input select
  logic [15:0] bg_reg, bg_next;       // band gap enables
  logic [15:0] slo_reg, slo_next;     // scan mask low
  logic [15:0] shi_reg, shi_next;     // scan mask high
  logic [15:0] ctrl_reg, ctrl_next;   // control bits
  // bus answer
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  // input synchronisers, stage 1 feeds stage 2 only
  logic [2:0]  rc_s_reg, rc_s_next;
  logic [2:0]  dn_s_reg, dn_s_next;
  // sequencer
  acs_pkg::acs_state_e st_reg, st_next;
  logic [4:0]  cnt_reg, cnt_next;     // sample time count
  logic        alt_reg, alt_next;     // 1 = second setting next
  logic        done_reg, done_next;   // conversion done flag
  logic        cs_reg, cs_next;       // convert start pulse
  // core outputs
  logic [4:0]  pos_reg, pos_next;
  logic        neg_reg, neg_next;
  // decode helpers
  logic        req, wr;
  logic [15:0] lane;                  // byte lane mask
  logic [7:0]  a8;
  logic        wr_clkt, wr_insel, wr_scan, wr_ctrl;
  logic        samp_set, samp_clr;
  logic        on, auto_trig, use_b, done_rise;
  logic [4:0]  raw_pos;
  logic [15:0] shi_msk;

  // byte address, upper address bits must be zero
  assign a8   = wb_adr_i[7:0];
  assign req  = wb_cyc_i & wb_stb_i & ~ack_reg
              & ~|(wb_adr_i >> 8);
  assign wr   = req & wb_we_i;
  assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_clkt  = wr && a8 == acs_pkg::ADR_CLKTIME;
  assign wr_insel = wr && a8 == acs_pkg::ADR_INSEL;
  assign wr_scan  = wr && (a8 == acs_pkg::ADR_SCANLO
                        || a8 == acs_pkg::ADR_SCANHI);
  assign wr_ctrl  = wr && a8 == acs_pkg::ADR_CTRL;
  // sample bit write: 1 starts, 0 ends a manual sample
  assign samp_set = wr_ctrl & wb_sel_i[0]
                  & wb_dat_i[acs_pkg::CTRL_SAMP_BIT];
  assign samp_clr = wr_ctrl & wb_sel_i[0]
                  & ~wb_dat_i[acs_pkg::CTRL_SAMP_BIT];
  // small package hides pin bits of the high mask
  assign shi_msk  = SMALL_PKG ? acs_pkg::MSK_SCANHI_SMALL
                              : acs_pkg::MSK_SCANHI;  // see [RULE14]

  // register writes, masked to implemented bits
  always_comb begin
    clkt_next  = clkt_reg;
    insel_next = insel_reg;
    bg_next    = bg_reg;
    slo_next   = slo_reg;
    shi_next   = shi_reg;
    ctrl_next  = ctrl_reg;
    if (wr) begin
      case (a8)
        // reserved bits stored as written, software keeps them zero
        acs_pkg::ADR_CLKTIME: clkt_next = (clkt_reg & ~lane)
          | (wb_dat_i[15:0] & lane & acs_pkg::MSK_CLKTIME); // see [RULE2]
        acs_pkg::ADR_INSEL: insel_next = (insel_reg & ~lane)
          | (wb_dat_i[15:0] & lane & acs_pkg::MSK_INSEL);
        acs_pkg::ADR_BGCFG: bg_next = (bg_reg & ~lane)
          | (wb_dat_i[15:0] & lane & acs_pkg::MSK_BGCFG); // see [RULE12]
        acs_pkg::ADR_SCANLO: slo_next = (slo_reg & ~lane)
          | (wb_dat_i[15:0] & lane);                      // see [RULE13]
        acs_pkg::ADR_SCANHI: shi_next = (shi_reg & ~lane)
          | (wb_dat_i[15:0] & lane & shi_msk);            // see [RULE15]
        acs_pkg::ADR_CTRL: ctrl_next = (ctrl_reg & ~lane)
          | (wb_dat_i[15:0] & lane & acs_pkg::MSK_CTRL);
        default: ;  // unmapped or read-only: write dropped
      endcase
    end
  end

  // read mux and one-cycle ack, unmapped reads give zero
  always_comb begin
    ack_next = req;
    dat_next = dat_reg;
    if (req && !wb_we_i) begin
      case (a8)
        acs_pkg::ADR_CLKTIME: dat_next = {16'h0000, clkt_reg};
        acs_pkg::ADR_INSEL:   dat_next = {16'h0000, insel_reg};
        acs_pkg::ADR_BGCFG:   dat_next = {16'h0000, bg_reg};
        acs_pkg::ADR_SCANLO:  dat_next = {16'h0000, slo_reg};
        acs_pkg::ADR_SCANHI:  dat_next = {16'h0000, shi_reg};
        // sample bit reads back the live sampling state
        acs_pkg::ADR_CTRL: dat_next = {16'h0000, ctrl_reg
          | {14'h0000, (st_reg == acs_pkg::ST_SAMPLE), 1'b0}};
        acs_pkg::ADR_STAT: dat_next = {16'h0000, 3'h0,
          cif.scan_idx, 4'h0, done_reg, alt_reg,
          (st_reg == acs_pkg::ST_CONV),
          (st_reg == acs_pkg::ST_SAMPLE)};
        default: dat_next = 32'h0000_0000;
      endcase
    end
  end

  // synchroniser shift: pins pass two flops before use
  always_comb begin
    rc_s_next = {rc_s_reg[1:0], rc_clk_i};
    dn_s_next = {dn_s_reg[1:0], conv_done_i};
  end

  // edges taken from stages 2 and 3 only
  assign done_rise    = dn_s_reg[1] & ~dn_s_reg[2];
  assign on           = ctrl_reg[acs_pkg::CTRL_ON_BIT];
  assign auto_trig    = ctrl_reg[acs_pkg::CTRL_TRIG_LSB +: 3]
                        == acs_pkg::TRIG_AUTO;
  assign use_b        = ctrl_reg[acs_pkg::CTRL_ALT_BIT] & alt_reg;

  // divider and scan stepper hookup
  assign cif.ce           = ce_i;
  assign cif.clk_src_rc   = clkt_reg[acs_pkg::CLK_SRC_BIT]; // see [RULE1]
  assign cif.div          = clkt_next[acs_pkg::DIV_LSB +: 8];
  assign cif.restart      = wr_clkt;                        // see [RULE20]
  assign cif.rc_rise      = rc_s_reg[1] & ~rc_s_reg[2];
  assign cif.scan_mask    = {shi_reg[11:0], slo_reg};
  // restart scanning on any change to its setup
  assign cif.scan_restart = ~on | wr_scan | wr_ctrl;
  // step only after a first-setting sample
  assign cif.scan_advance = (st_reg == acs_pkg::ST_CONV) & done_rise
                          & ctrl_reg[acs_pkg::CTRL_SCAN_BIT] & ~use_b;

  acs_clkdiv u_clkdiv (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif.clkdiv)
  );

  acs_scan u_scan (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (cif.scan)
  );

  // sample / convert sequencer
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    alt_next  = alt_reg;
    done_next = done_reg;
    cs_next   = 1'b0;
    case (st_reg)
      acs_pkg::ST_IDLE: begin
        if (!on) begin
          alt_next = 1'b0;  // next run starts on first setting
        end else if (samp_set) begin
          st_next   = acs_pkg::ST_SAMPLE;
          cnt_next  = 5'h00;
          done_next = 1'b0;
        end
      end
      acs_pkg::ST_SAMPLE: begin
        if (!on) begin
          st_next = acs_pkg::ST_IDLE;
        end else if (auto_trig) begin
          // count whole periods, zero ends at once
          if (cnt_reg == clkt_reg[acs_pkg::AUTO_SAMPLE_COUNT_LSB +: 5]) begin
            st_next = acs_pkg::ST_CONV;          // see [RULE16]
            cs_next = 1'b1;
          end else if (cif.tad_tick) begin
            cnt_next = cnt_reg + 5'h01;          // see [RULE3]
          end
        end else if (samp_clr) begin
          // manual: clearing the sample bit converts
          st_next = acs_pkg::ST_CONV;
          cs_next = 1'b1;
        end
      end
      acs_pkg::ST_CONV: begin
        if (!on) begin
          st_next = acs_pkg::ST_IDLE;
        end else if (done_rise) begin
          done_next = 1'b1;
          // first sample used first setting, then alternate
          alt_next = ctrl_reg[acs_pkg::CTRL_ALT_BIT]
                   & ~alt_reg;                   // see [RULE17]
          cnt_next = 5'h00;
          // auto start resamples right after conversion
          st_next = ctrl_reg[acs_pkg::CTRL_ASAM_BIT]
                  ? acs_pkg::ST_SAMPLE : acs_pkg::ST_IDLE;
        end
      end
      default: st_next = acs_pkg::ST_IDLE;
    endcase
  end

  // positive select source before legality check
  always_comb begin
    if (use_b) begin
      raw_pos = insel_reg[acs_pkg::POSB_LSB +: 5];  // see [RULE6]
    end else if (ctrl_reg[acs_pkg::CTRL_SCAN_BIT]) begin
      // empty mask leaves the input floating
      raw_pos = cif.scan_any ? cif.scan_idx
                             : acs_pkg::CODE_FLOAT; // see [RULE18]
    end else begin
      raw_pos = insel_reg[acs_pkg::POSA_LSB +: 5];  // see [RULE9]
    end
  end

  // drive the analog multiplexer; bad codes float the input
  always_comb begin
    pos_next = acs_pkg::CODE_FLOAT;  // see [RULE7]
    if (raw_pos <= (SMALL_PKG ? acs_pkg::CODE_LAST_AN_SMALL
                              : acs_pkg::CODE_LAST_AN)) begin
      pos_next = raw_pos;            // see [RULE10]
    end else if (raw_pos >= acs_pkg::CODE_BG_HALF
              && raw_pos <= acs_pkg::CODE_BG_SIXTH) begin
      pos_next = raw_pos;            // see [RULE6]
    end
    neg_next = use_b ? insel_reg[acs_pkg::NEGB_BIT]   // see [RULE5]
                     : insel_reg[acs_pkg::NEGA_BIT];  // see [RULE8]
  end

  // all state registers, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clkt_reg  <= acs_pkg::RST_REG16;
      insel_reg <= acs_pkg::RST_REG16;
      bg_reg    <= acs_pkg::RST_REG16;
      slo_reg   <= acs_pkg::RST_REG16;
      shi_reg   <= acs_pkg::RST_REG16;
      ctrl_reg  <= acs_pkg::RST_REG16;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      rc_s_reg  <= 3'h0;
      dn_s_reg  <= 3'h0;
      st_reg    <= acs_pkg::ST_IDLE;
      cnt_reg   <= 5'h00;
      alt_reg   <= 1'b0;
      done_reg  <= 1'b0;
      cs_reg    <= 1'b0;
      pos_reg   <= 5'h00;
      neg_reg   <= 1'b0;
    end else if (ce_i) begin
      clkt_reg  <= clkt_next;
      insel_reg <= insel_next;
      bg_reg    <= bg_next;
      slo_reg   <= slo_next;
      shi_reg   <= shi_next;
      ctrl_reg  <= ctrl_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      rc_s_reg  <= rc_s_next;
      dn_s_reg  <= dn_s_next;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      alt_reg   <= alt_next;
      done_reg  <= done_next;
      cs_reg    <= cs_next;
      pos_reg   <= pos_next;
      neg_reg   <= neg_next;
    end
  end

  // outputs, all from flops
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = dat_reg;
  assign conv_clk_o      = cif.conv_clk;
  assign sample_o        = st_reg[1];
  assign convert_start_o = cs_reg;
  assign pos_sel_o       = pos_reg;
  assign neg_ain1_o      = neg_reg;
  assign bg_sixth_en_o   = bg_reg[acs_pkg::BG_SIXTH_BIT]; // see [RULE11]
  assign bg_half_en_o    = bg_reg[acs_pkg::BG_HALF_BIT];  // see [RULE11]
  assign bg_full_en_o    = bg_reg[acs_pkg::BG_FULL_BIT];  // see [RULE11]
endmodule : acs_top

/* File: tb/acs_top_checker.sv */
// port-level assertions for the converter control block
`timescale 1ns/10ps
module acs_top_checker #(
  parameter int ADR_W = 8  // address width, handed on by the bind
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             sample_o,
  input wire logic             convert_start_o,
  input wire logic [4:0]       pos_sel_o,
  input wire logic             neg_ain1_o,
  input wire logic             bg_sixth_en_o,
  input wire logic             bg_half_en_o,
  input wire logic             bg_full_en_o
);
  // request taken at this edge, and its low-lane write form
  wire logic tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  wire logic wr = tk & wb_we_i & wb_sel_i[0];
  wire logic bg = wb_adr_i == ADR_W'(acs_pkg::ADR_BGCFG);
  wire logic is = wb_adr_i == ADR_W'(acs_pkg::ADR_INSEL);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_take; tk |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack missing");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_bg_en; wr && bg |=>
    {bg_sixth_en_o, bg_half_en_o, bg_full_en_o} == $past(wb_dat_i[2:0]);
  endproperty
  a_bg_en: assert property (p_bg_en) else $error("bg enable");
  property p_bg_rd; tk && !wb_we_i && bg |=> wb_dat_o[15:3] == 13'h0;
  endproperty
  a_bg_rd: assert property (p_bg_rd) else $error("bg upper");
  // both lanes agree, so either mux setting must show the same level
  property p_neg; wr && is && wb_sel_i[1] && wb_dat_i[7] == wb_dat_i[15]
    |-> ##2 neg_ain1_o == $past(wb_dat_i[7], 2);
  endproperty
  a_neg: assert property (p_neg) else $error("neg sel");
  property p_cs_fell; convert_start_o |-> $fell(sample_o); endproperty
  a_cs_fell: assert property (p_cs_fell) else $error("start");
  property p_cs_pulse; convert_start_o |=> !convert_start_o; endproperty
  a_cs_pulse: assert property (p_cs_pulse) else $error("cs");
  property p_code; !(pos_sel_o inside {5'h1c, 5'h1d, 5'h1e}); endproperty
  a_code: assert property (p_code) else $error("code");
endmodule : acs_top_checker

/* File: tb/acs_analog_model.sv */
// analog core stand-in: captures the input code, answers done later
`timescale 1ns/10ps
module acs_analog_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic       slow_i,
  input  wire logic [4:0] code_i,
  output logic            done_o,
  output logic [4:0]      code_o,
  output int              cnt_o
);
  int t = 0;  // cycles left in the conversion
  initial begin
    done_o = 0;
    code_o = 0;
    cnt_o  = 0;
  end
  // slow mode stretches the conversion well past the sync latency
  always @(posedge clk_i) begin
    done_o <= 0;
    if (start_i) begin
      code_o <= code_i;
      t      <= slow_i ? 40 : 6;
    end else if (t > 1) t <= t - 1;
    else if (t == 1) begin
      t      <= 0;
      done_o <= 1;
      cnt_o  <= cnt_o + 1;
    end
  end
endmodule : acs_analog_model

/* File: tb/acs_top_bench.sv */
// self-checking bench for the converter clock, input and scan block
`timescale 1ns/10ps
module acs_top_bench;
  logic        clk_i = 0, rst_i = 1;         // clock, sync reset
  logic        cyc = 0, stb = 0, we = 0;     // wishbone request
  logic [7:0]  adr = 0;                      // byte address
  logic [31:0] wdat = 0, dat_o;              // bus data
  logic [3:0]  sel = 0;                      // byte lanes
  logic        rc_clk = 0, rc_run = 0;       // rc oscillator stand-in
  logic        slow = 0;                     // partner answers slowly
  logic        ack, cclk, samp, cst, neg, bg6, bg2, bg1, done;
  logic [4:0]  pos, code;
  logic [31:0] seed = 32'h44;                // xorshift state
  logic [15:0] q, d;
  int          cnt, n, err_total = 0, n_tests = 0, ticks = 0;
  // readable bits and legal write bits per register
  logic [15:0] rm [5] = '{16'hffff, 16'h9f9f, 16'h7, 16'hffff, 16'hfff};
  logic [15:0] wm [5] = '{16'h9fff, 16'h9797, 16'hffff, 16'hffff, 16'hffff};
  acs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rc_clk_i(rc_clk), .conv_done_i(done), .conv_clk_o(cclk),
    .sample_o(samp), .convert_start_o(cst), .pos_sel_o(pos),
    .neg_ain1_o(neg), .bg_sixth_en_o(bg6), .bg_half_en_o(bg2),
    .bg_full_en_o(bg1));
  acs_analog_model i_core (.clk_i(clk_i), .start_i(cst), .slow_i(slow),
    .code_i(pos), .done_o(done), .code_o(code), .cnt_o(cnt));
  initial forever #20 clk_i = ~clk_i;
  // rc stand-in toggles every third clock; hang guard
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (rc_run && ticks % 3 == 0) rc_clk <= ~rc_clk;
    if (ticks == 30000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // one classic cycle; waits for ack, releases at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] dw, output logic [15:0] dr);
    @(posedge clk_i);
    cyc  <= 1;
    stb  <= 1;
    we   <= w;
    adr  <= a;
    wdat <= {16'h0, dw};
    sel  <= 4'h3;
    do @(posedge clk_i); while (ack !== 1'b1);
    dr = dat_o[15:0];
    cyc <= 0;
    stb <= 0;
  endtask : wb
  // cycles up to the next rising conversion clock edge
  task automatic rise(output int r);
    r = 0;
    do begin @(negedge clk_i); r++; end while (cclk !== 1'b0);
    do begin @(negedge clk_i); r++; end while (cclk !== 1'b1);
  endtask : rise
  // changes of the conversion clock over 40 cycles
  task automatic chg(output int r);
    logic p;
    r = 0;
    p = cclk;
    repeat (40) begin
      @(negedge clk_i);
      if (cclk !== p) r++;
      p = cclk;
    end
  endtask : chg
  // runs five conversions and compares each captured input code
  task automatic seq(input logic [15:0] c, input logic [4:0] e [5]);
    int b;
    b = cnt;
    wb(1, 8'h14, c & 16'h8000, q);
    wb(1, 8'h14, c, q);
    for (int k = 0; k < 5; k++) begin
      wait (cnt == b + k + 1);
      cmp("code", e[k], code);
    end
    wb(1, 8'h14, 16'h0, q);
    repeat (60) @(posedge clk_i);
  endtask : seq
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    // reset values, random readback, unused bits
    for (int i = 0; i < 5; i++) begin
      wb(0, 8'(4 * i), 16'h0, q);
      cmp("reset", 0, q);
      d = 16'(rnd()) & wm[i];
      wb(1, 8'(4 * i), d, q);
      wb(0, 8'(4 * i), 16'h0, q);
      cmp("readback", d & rm[i], q);
      if (i == 2) cmp("bg", d[2:0], {bg6, bg2, bg1});
    end
    wb(1, 8'h1c, 16'hffff, q);
    wb(0, 8'h1c, 16'h0, q);
    cmp("unmapped", 0, q);
    // every positive code, unlisted ones included
    for (int c = 0; c < 32; c++) begin
      d = {8'h0, c[0], 2'b0, 5'(c)};
      wb(1, 8'h04, {d[7:0], d[7:0]}, q);
      repeat (3) @(negedge clk_i);
      cmp("select", {c[0], (c < 28 || c == 31) ? 5'(c) : 5'h1f},
          {neg, pos});
    end
    // divided clock period from random dividers
    for (int k = 0; k < 3; k++) begin
      d = 16'(rnd() % 6);
      wb(1, 8'h00, d, q);
      rise(n);
      rise(n);
      cmp("period", 2 * (d + 1), n);
    end
    // rc source: still oscillator gives no clock
    wb(1, 8'h00, 16'h8000, q);
    chg(n);
    cmp("rc idle", 0, n);
    rc_run <= 1;
    chg(n);
    cmp("rc run", 1, n > 0);
    rc_run <= 0;
    // auto trigger: five ticks of two clocks each
    wb(1, 8'h00, 16'h0500, q);
    wb(1, 8'h14, 16'h8000, q);
    wb(1, 8'h14, 16'h80e2, q);
    @(negedge clk_i);
    n = 0;
    while (samp === 1'b1) begin @(negedge clk_i); n++; end
    cmp("sample", 1, n >= 8 && n <= 13);
    wb(1, 8'h14, 16'h0, q);
    wb(1, 8'h00, 16'h0100, q);
    wb(1, 8'h0c, 16'h0005, q);
    wb(1, 8'h10, 16'h0101, q);
    seq(16'h84e6,'{0,2,16,24,0});
    slow <= 1;
    wb(1, 8'h04, 16'h0503, q);
    seq(16'h80e7, '{3, 5, 3, 5, 3});
    complete_run();
  end
endmodule : acs_top_bench
bind acs_top acs_top_checker #(.ADR_W(ADR_W)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_o(sample_o), .convert_start_o(convert_start_o),
  .pos_sel_o(pos_sel_o), .neg_ain1_o(neg_ain1_o),
  .bg_sixth_en_o(bg_sixth_en_o), .bg_half_en_o(bg_half_en_o),
  .bg_full_en_o(bg_full_en_o));
